// file: hdl/cmf_pkg.sv
// constants and types shared by the message object fifo block
// Contract
// - mode 010 marks a fifo base object, 011 a slave; mask sets buffer length.
// - a transmit fifo sends with the identifier of the addressed element.
// - every element keeps its own status flags and interrupt enables.
// - new pointer keeps bits outside mask and takes incremented bits inside.
// - advance direction 0 moves the pointer on receive actions.
// - advance direction 1 moves the pointer on transmit actions.
// - receive fifo fills base first, then next elements, then wraps.
// - overwriting an unread receive element sets its data lost flag.
// - transmit fifo starts at base and steps after each transmission.
// - an invalid addressed element blocks the fifo only when the base is invalid too.
// - valid base with invalid addressed slave skips the store but advances.
// - remote frame on a transmit fifo sets request and pending on the match.
// - host register access never changes the pointer by itself.
// - an object is operable only when its valid field is 10.
`default_nettype none
package cmf_pkg;
  localparam int OBJ_COUNT = 32;
  localparam logic [2:0] MODE_PLAIN = 3'h0;
  localparam logic [2:0] MODE_BASE = 3'h2;
  localparam logic [2:0] MODE_SLAVE = 3'h3;
  localparam logic [1:0] VAL_ON = 2'h2;
  localparam logic [1:0] VAL_OFF = 2'h1;
  // control word field positions
  localparam int F_VALID = 0;
  localparam int F_NEW_DATA_FLAG = 2;
  localparam int F_LOST = 3;
  localparam int F_LOCK = 4;
  localparam int F_SENDRQ = 5;
  localparam int F_REMOTE_PENDING = 6;
  localparam int F_DIR = 7;
  localparam int F_MODE = 8;
  localparam int F_MASK = 11;
  localparam int F_FDIR = 16;
  localparam int F_PTR = 17;
  localparam int F_XTD = 22;
  localparam int F_RXIE = 23;
  localparam int F_TXIE = 24;
  // byte map: object n control at n*8, identifier at n*8+4
  localparam logic [11:0] MAP_END = 12'h100;
  typedef struct packed {
    logic [1:0] objValid;
    logic newData;
    logic dataLost;
    logic hostLock;
    logic sendReq;
    logic remotePending;
    logic dirFlag;
    logic [2:0] mode;
    logic [4:0] bufLenMask;
    logic fifoAdvDir;
    logic [4:0] elemPtr;
    logic extIdFlag;
    logic rxIntEn;
    logic txIntEn;
    logic [28:0] ident;
  } cmf_obj_t;
  localparam cmf_obj_t OBJ_RESET = '{objValid: VAL_OFF, default: '0};
endpackage : cmf_pkg
`default_nettype wire

// file: hdl/cmf_reg_if.sv
// register access carrier between bus slave and object table
`default_nettype none
interface cmf_reg_if;
  logic wrEn;
  logic [4:0] obj;
  logic word;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus (output wrEn, obj, word, wdata, input rdata);
  modport core (input wrEn, obj, word, wdata, output rdata);
endinterface : cmf_reg_if
`default_nettype wire

// file: hdl/cmf_apb_slave.sv
// apb slave: zero wait states, read data captured in setup phase
`default_nettype none
module cmf_apb_slave
  import cmf_pkg::*;
(
  input wire logic mclk, // module clock
  input wire logic rst, // async reset
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // write
  input wire logic [11:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // always ready
  output logic pslverr, // unmapped access
  cmf_reg_if.bus rif // object table side
);
  typedef struct packed {
    logic [31:0] rdData;
  } cmf_apb_t;
  cmf_apb_t s_reg;
  cmf_apb_t s_next;
  logic mapped;

  assign mapped = paddr < MAP_END;
  assign rif.obj = paddr[7:3];
  assign rif.word = paddr[2];
  assign rif.wdata = pwdata;
  assign rif.wrEn = psel & penable & pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s_reg.rdData;

  always_comb begin
    s_next = s_reg;
    if (psel && !penable) begin
      s_next.rdData = mapped ? rif.rdata : 32'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : cmf_apb_slave
`default_nettype wire

// file: hdl/cmf_ptr_step.sv
// circular pointer step inside the length mask
`default_nettype none
module cmf_ptr_step (
  input wire logic [4:0] ptrOld, // current pointer
  input wire logic [4:0] lenMask, // buffer length mask
  output logic [4:0] ptrNew // stepped pointer
);
  logic [4:0] inc;
  assign inc = ptrOld + 5'h1;
  assign ptrNew = (ptrOld & ~lenMask) | (inc & lenMask);
endmodule : cmf_ptr_step
`default_nettype wire

// file: hdl/cmf_fifo_ctrl.sv
// message object table with circular fifo pointer handling
//
// Our own choices: the register offsets and the APB slave port.
`default_nettype none
module cmf_fifo_ctrl
  import cmf_pkg::*;
#(
  parameter int NumObj = OBJ_COUNT
) (
  input wire logic mclk, // module clock
  input wire logic rst, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic evtValid, // node event pulse
  input wire logic [4:0] evtObj, // matched or sent object
  input wire logic evtRemote, // frame is remote
  input wire logic evtTx, // 1 sent, 0 received
  input wire logic evtOk, // frame completed cleanly
  output logic storeValid, // write frame data pulse
  output logic [4:0] storeObj, // object to store into
  output logic blockPulse, // fifo blocked event
  output logic txValid, // transmit candidate present
  output logic [4:0] txObj, // object to transmit
  output logic [28:0] txIdent // identifier to transmit
);
  typedef struct packed {
    cmf_obj_t [NumObj-1:0] obj;
    logic storeValid;
    logic [4:0] storeObj;
    logic blockEvt;
    logic txValid;
    logic [4:0] txObj;
    logic [28:0] txIdent;
  } cmf_state_t;

  cmf_state_t s_reg;
  cmf_state_t s_next;
  cmf_reg_if rif ();

  cmf_apb_slave u_apb (
    .mclk(mclk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif)
  );

  function automatic logic [31:0] ctrlWord(input cmf_obj_t o);
    logic [31:0] w;
    w = 32'h0;
    w[F_VALID+:2] = o.objValid;
    w[F_NEW_DATA_FLAG] = o.newData;
    w[F_LOST] = o.dataLost;
    w[F_LOCK] = o.hostLock;
    w[F_SENDRQ] = o.sendReq;
    w[F_REMOTE_PENDING] = o.remotePending;
    w[F_DIR] = o.dirFlag;
    w[F_MODE+:3] = o.mode;
    w[F_MASK+:5] = o.bufLenMask;
    w[F_FDIR] = o.fifoAdvDir;
    w[F_PTR+:5] = o.elemPtr;
    w[F_XTD] = o.extIdFlag;
    w[F_RXIE] = o.rxIntEn;
    w[F_TXIE] = o.txIntEn;
    return w;
  endfunction : ctrlWord

  function automatic logic isFifo(input logic [2:0] m);
    return (m == MODE_BASE) || (m == MODE_SLAVE);
  endfunction : isFifo

  function automatic logic canSend(input cmf_obj_t o);
    return (o.objValid == VAL_ON) && o.sendReq && !o.hostLock;
  endfunction : canSend

  // event decode
  cmf_obj_t evtEnt;
  cmf_obj_t baseEnt;
  cmf_obj_t addrEnt;
  logic inFifo;
  logic [4:0] baseNum;
  logic [4:0] addrNum;
  logic [4:0] ptrNext;
  logic evtDone;
  logic addrOk;
  logic blocked;
  logic doStore;
  logic doRemote;
  logic doAdvance;

  assign evtDone = evtValid & evtOk;
  assign evtEnt = s_reg.obj[evtObj];
  assign inFifo = isFifo(evtEnt.mode);
  // slaves hold the base number in their pointer
  assign baseNum = (evtEnt.mode == MODE_SLAVE) ? evtEnt.elemPtr : evtObj;
  assign baseEnt = s_reg.obj[baseNum];
  assign addrNum = inFifo ? baseEnt.elemPtr : evtObj;
  assign addrEnt = s_reg.obj[addrNum];
  assign addrOk = addrEnt.objValid == VAL_ON;
  // invalid addressed element halts the fifo unless base is valid
  assign blocked = inFifo && !addrOk && (addrNum == baseNum || baseEnt.objValid != VAL_ON);
  assign doStore = evtDone && !evtTx && !evtRemote && !addrEnt.dirFlag && addrOk;
  assign doRemote = evtDone && !evtTx && evtRemote && evtEnt.dirFlag && !blocked
    && (inFifo || addrOk);
  assign doAdvance = evtDone && inFifo && !blocked && (baseEnt.fifoAdvDir == evtTx);

  cmf_ptr_step u_step (
    .ptrOld(baseEnt.elemPtr),
    .lenMask(baseEnt.bufLenMask),
    .ptrNew(ptrNext)
  );

  assign rif.rdata = rif.word ? {3'h0, s_reg.obj[rif.obj].ident} : ctrlWord(s_reg.obj[rif.obj]);

  always_comb begin
    s_next = s_reg;
    s_next.storeValid = 1'b0;
    s_next.blockEvt = 1'b0;
    s_next.txValid = 1'b0;
    // host writes first so node updates below win the same cycle
    if (rif.wrEn) begin
      if (rif.word) begin
        s_next.obj[rif.obj].ident = rif.wdata[28:0];
      end else begin
        s_next.obj[rif.obj].objValid = rif.wdata[F_VALID+:2];
        s_next.obj[rif.obj].newData = rif.wdata[F_NEW_DATA_FLAG];
        s_next.obj[rif.obj].dataLost = rif.wdata[F_LOST];
        s_next.obj[rif.obj].hostLock = rif.wdata[F_LOCK];
        s_next.obj[rif.obj].sendReq = rif.wdata[F_SENDRQ];
        s_next.obj[rif.obj].remotePending = rif.wdata[F_REMOTE_PENDING];
        s_next.obj[rif.obj].dirFlag = rif.wdata[F_DIR];
        s_next.obj[rif.obj].mode = rif.wdata[F_MODE+:3];
        s_next.obj[rif.obj].bufLenMask = rif.wdata[F_MASK+:5];
        s_next.obj[rif.obj].fifoAdvDir = rif.wdata[F_FDIR];
        s_next.obj[rif.obj].elemPtr = rif.wdata[F_PTR+:5];
        s_next.obj[rif.obj].extIdFlag = rif.wdata[F_XTD];
        s_next.obj[rif.obj].rxIntEn = rif.wdata[F_RXIE];
        s_next.obj[rif.obj].txIntEn = rif.wdata[F_TXIE];
      end
    end
    if (evtDone) begin
      if (blocked) begin
        s_next.blockEvt = 1'b1;
      end
      if (doStore) begin
        // unread data being replaced
        if (addrEnt.newData) begin
          s_next.obj[addrNum].dataLost = 1'b1;
        end
        s_next.obj[addrNum].newData = 1'b1;
        s_next.storeValid = 1'b1;
        s_next.storeObj = addrNum;
      end
      if (doRemote) begin
        s_next.obj[evtObj].sendReq = 1'b1;
        s_next.obj[evtObj].remotePending = 1'b1;
      end
      if (evtTx) begin
        s_next.obj[evtObj].sendReq = 1'b0;
        s_next.obj[evtObj].remotePending = 1'b0;
      end
      // skipped store into an invalid slave still advances
      if (doAdvance) begin
        s_next.obj[baseNum].elemPtr = ptrNext;
      end
    end
    // lowest numbered ready plain object or fifo base wins; fifos offer their addressed element
    for (int i = NumObj - 1; i >= 0; i--) begin
      if (s_reg.obj[i].mode == MODE_PLAIN && canSend(s_reg.obj[i])) begin
        s_next.txValid = 1'b1;
        s_next.txObj = 5'(i);
      end else if (s_reg.obj[i].mode == MODE_BASE && canSend(s_reg.obj[s_reg.obj[i].elemPtr])) begin
        s_next.txValid = 1'b1;
        s_next.txObj = s_reg.obj[i].elemPtr;
      end
    end
    s_next.txIdent = s_reg.obj[s_next.txObj].ident;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '{obj: {NumObj{OBJ_RESET}}, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign storeValid = s_reg.storeValid;
  assign storeObj = s_reg.storeObj;
  assign blockPulse = s_reg.blockEvt;
  assign txValid = s_reg.txValid;
  assign txObj = s_reg.txObj;
  assign txIdent = s_reg.txIdent;

  a_ptr_wraps: assert property (@(posedge mclk) disable iff (rst)
    doAdvance |=> s_reg.obj[$past(baseNum)].elemPtr ==
      (($past(baseEnt.elemPtr) & ~$past(baseEnt.bufLenMask))
      | (5'($past(baseEnt.elemPtr) + 5'h1) & $past(baseEnt.bufLenMask))))
    else $error("fifo pointer step wrong");

  a_block_no_move: assert property (@(posedge mclk) disable iff (rst)
    evtDone && blocked && !(rif.wrEn && !rif.word) |=> !s_reg.storeValid && s_reg.blockEvt
      && s_reg.obj[$past(baseNum)].elemPtr == $past(baseEnt.elemPtr))
    else $error("blocked fifo still moved or stored");

  a_lost_on_over: assert property (@(posedge mclk) disable iff (rst)
    doStore && addrEnt.newData |=> s_reg.obj[$past(addrNum)].dataLost)
    else $error("overwrite without lost flag");

  a_store_target: assert property (@(posedge mclk) disable iff (rst)
    doStore |=> s_reg.storeValid && s_reg.storeObj == $past(addrNum)
      && s_reg.obj[$past(addrNum)].newData ##1 !s_reg.storeValid || $past(doStore))
    else $error("store pulse or target wrong");

  a_remote_sets: assert property (@(posedge mclk) disable iff (rst)
    doRemote |=> s_reg.obj[$past(evtObj)].sendReq && s_reg.obj[$past(evtObj)].remotePending)
    else $error("remote frame left request clear");

  a_skip_slave: assert property (@(posedge mclk) disable iff (rst)
    evtDone && inFifo && !addrOk && addrNum != baseNum && baseEnt.objValid == VAL_ON
      |=> !s_reg.storeValid)
    else $error("invalid slave was written");

  a_dir_gate: assert property (@(posedge mclk) disable iff (rst)
    evtDone && inFifo && baseEnt.fifoAdvDir != evtTx && !(rif.wrEn && !rif.word)
      |=> s_reg.obj[$past(baseNum)].elemPtr == $past(baseEnt.elemPtr))
    else $error("pointer moved on wrong action");

  a_abort_hold: assert property (@(posedge mclk) disable iff (rst)
    evtValid && !evtOk && !rif.wrEn |=> $stable(s_reg.obj) && !s_reg.storeValid)
    else $error("aborted frame changed the table");

  a_host_keeps: assert property (@(posedge mclk) disable iff (rst)
    rif.wrEn && rif.word && !evtValid |=> s_reg.obj[$past(rif.obj)].elemPtr == $past(s_reg.obj[rif.obj].elemPtr))
    else $error("host access moved pointer");

  a_read_still: assert property (@(posedge mclk) disable iff (rst)
    psel && !penable && !pwrite && !evtValid |=> $stable(s_reg.obj))
    else $error("host read changed the table");

  a_send_clear: assert property (@(posedge mclk) disable iff (rst)
    evtDone && evtTx |=> !s_reg.obj[$past(evtObj)].sendReq)
    else $error("sent object kept its request");

  a_plain_invalid: assert property (@(posedge mclk) disable iff (rst)
    evtDone && !inFifo && evtEnt.objValid != VAL_ON |=> !s_reg.storeValid)
    else $error("invalid object was written");
endmodule : cmf_fifo_ctrl
`default_nettype wire

// file: testbench/cmf_node_model.sv
// node controller model: turns bench requests into one-cycle event pulses
`default_nettype none
module cmf_node_model (
  input wire logic mclk, // module clock
  input wire logic rst, // async reset
  input wire logic go, // request one event
  input wire logic [4:0] obj, // object of the event
  input wire logic tx, // 1 sent, 0 received
  input wire logic remote, // remote frame
  input wire logic ok, // frame completed
  output logic evtValid, // event pulse
  output logic [4:0] evtObj, // event object
  output logic evtRemote, // remote flag
  output logic evtTx, // direction flag
  output logic evtOk // completion flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // qualifiers toggle outside events so a stale value is never mistaken for a real one
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evtValid <= 1'b0;
      evtObj <= 5'h0;
      evtRemote <= 1'b0;
      evtTx <= 1'b0;
      evtOk <= 1'b0;
    end else begin
      evtValid <= go;
      evtObj <= go ? obj : ~evtObj;
      evtRemote <= go ? remote : ~evtRemote;
      evtTx <= go ? tx : ~evtTx;
      evtOk <= go ? ok : ~evtOk;
    end
  end
endmodule : cmf_node_model
`default_nettype wire

// file: testbench/can_message_object_fifo_tb_top.sv
// self-checking bench for the message object fifo block
`default_nettype none
module can_message_object_fifo_tb_top;
  import cmf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, storeValid, blockPulse, txValid, evtValid, evtRemote, evtTx, evtOk;
  logic go = 1'b0, tx = 1'b0, remote = 1'b0, ok = 1'b0;
  logic [4:0] obj = 5'h0, evtObj, storeObj, txObj, p;
  logic [28:0] txIdent, id8, id9;
  int errors = 0, n_checks = 0;
  cmf_fifo_ctrl uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtValid(evtValid), .evtObj(evtObj),
    .evtRemote(evtRemote), .evtTx(evtTx), .evtOk(evtOk), .storeValid(storeValid), .storeObj(storeObj),
    .blockPulse(blockPulse), .txValid(txValid), .txObj(txObj), .txIdent(txIdent));
  cmf_node_model node (.mclk(mclk), .rst(rst), .go(go), .obj(obj), .tx(tx), .remote(remote), .ok(ok),
    .evtValid(evtValid), .evtObj(evtObj), .evtRemote(evtRemote), .evtTx(evtTx), .evtOk(evtOk));
  initial begin
    forever #25 mclk = ~mclk;
  end
  task automatic give_verdict;
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one node event; returns in the cycle where the answer stands
  task automatic ev(input logic [4:0] o, input logic t, input logic r, input logic k);
    @(posedge mclk);
    go <= 1'b1;
    obj <= o;
    tx <= t;
    remote <= r;
    ok <= k;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : ev
  function automatic logic [31:0] mk(input logic [1:0] v, input logic sr, input logic d, input logic [2:0] m,
                                     input logic [4:0] k, input logic fd, input logic [4:0] pt);
    mk = 32'(v) | (32'(sr) << F_SENDRQ) | (32'(d) << F_DIR) | (32'(m) << F_MODE) | (32'(k) << F_MASK)
      | (32'(fd) << F_FDIR) | (32'(pt) << F_PTR);
  endfunction : mk
  function automatic logic [4:0] step(input logic [4:0] pt, input logic [4:0] k);
    step = (pt & ~k) | ((pt + 5'h1) & k);
  endfunction : step
  initial begin
    #2000000;
    errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hef6cbbe6));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("reset ctrl", rd, 32'(VAL_OFF));
    apb(1'b1, 12'h100, 32'hffffffff);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    // receive fifo of four at object 0
    id8 = 29'($urandom);
    for (int n = 0; n < 4; n++) begin
      apb(1'b1, 12'(n * 8 + 4), 32'(id8));
      apb(1'b1, 12'(n * 8), mk(VAL_ON, 1'b0, 1'b0, n == 0 ? MODE_BASE : MODE_SLAVE, 5'h3, 1'b0, 5'h0));
    end
    p = 5'h0;
    for (int i = 0; i < 5; i++) begin
      ev(5'($urandom % 4), 1'b0, 1'b0, 1'b1);
      chk("rx store", 32'(storeValid), 32'h1);
      chk("rx target", 32'(storeObj), 32'(p));
      p = step(p, 5'h3);
    end
    ev(5'h1, 1'b0, 1'b0, 1'b0);
    chk("aborted store", 32'(storeValid), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("wrapped base", rd, mk(VAL_ON, 1'b0, 1'b0, MODE_BASE, 5'h3, 1'b0, 5'h1) | 32'hc);
    apb(1'b1, 12'h010, mk(VAL_OFF, 1'b0, 1'b0, MODE_SLAVE, 5'h3, 1'b0, 5'h0));
    for (int i = 0; i < 3; i++) begin
      ev(5'h3, 1'b0, 1'b0, 1'b1);
      chk("skip store", 32'(storeValid), 32'(p != 5'h2));
      chk("skip block", 32'(blockPulse), 32'h0);
      p = step(p, 5'h3);
    end
    apb(1'b0, 12'h000, 32'h0);
    chk("skip ptr", 32'(rd[F_PTR+:5]), 32'(p));
    apb(1'b1, 12'h000, mk(VAL_OFF, 1'b0, 1'b0, MODE_BASE, 5'h3, 1'b0, 5'h0));
    ev(5'h2, 1'b0, 1'b0, 1'b1);
    chk("blocked", 32'(blockPulse), 32'h1);
    chk("blocked store", 32'(storeValid), 32'h0);
    // transmit fifo of two at object 8
    id8 = 29'($urandom);
    id9 = 29'($urandom);
    apb(1'b1, 12'h044, 32'(id8));
    apb(1'b1, 12'h04c, 32'(id9));
    apb(1'b1, 12'h040, mk(VAL_ON, 1'b1, 1'b1, MODE_BASE, 5'h1, 1'b1, 5'h8));
    apb(1'b1, 12'h048, mk(VAL_ON, 1'b1, 1'b1, MODE_SLAVE, 5'h1, 1'b1, 5'h8));
    repeat (3) @(posedge mclk);
    #1;
    chk("tx valid", 32'(txValid), 32'h1);
    chk("tx first", 32'(txObj), 32'h8);
    chk("tx ident", 32'(txIdent), 32'(id8));
    ev(5'h8, 1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge mclk);
    #1;
    chk("tx next", 32'(txObj), 32'h9);
    chk("tx next ident", 32'(txIdent), 32'(id9));
    ev(5'h8, 1'b0, 1'b1, 1'b1);
    apb(1'b0, 12'h040, 32'h0);
    chk("remote mark", rd, mk(VAL_ON, 1'b1, 1'b1, MODE_BASE, 5'h1, 1'b1, 5'h9) | 32'h40);
    // plain objects: lowest ready number wins, a lock or an invalid field stops them
    apb(1'b1, 12'h024, 32'(id9));
    apb(1'b1, 12'h020, mk(VAL_ON, 1'b1, 1'b1, MODE_PLAIN, 5'h0, 1'b0, 5'h0));
    repeat (3) @(posedge mclk);
    #1;
    chk("plain first", 32'(txObj), 32'h4);
    chk("plain ident", 32'(txIdent), 32'(id9));
    apb(1'b1, 12'h020, mk(VAL_ON, 1'b1, 1'b1, MODE_PLAIN, 5'h0, 1'b0, 5'h0) | 32'h10);
    repeat (3) @(posedge mclk);
    #1;
    chk("locked skipped", 32'(txObj), 32'h9);
    chk("locked ident", 32'(txIdent), 32'(id9));
    apb(1'b1, 12'h028, mk(VAL_ON, 1'b0, 1'b0, MODE_PLAIN, 5'h0, 1'b0, 5'h0));
    ev(5'h5, 1'b0, 1'b0, 1'b1);
    chk("plain store", 32'(storeValid), 32'h1);
    chk("plain target", 32'(storeObj), 32'h5);
    apb(1'b1, 12'h028, mk(VAL_OFF, 1'b0, 1'b0, MODE_PLAIN, 5'h0, 1'b0, 5'h0));
    ev(5'h5, 1'b0, 1'b0, 1'b1);
    chk("invalid plain", 32'(storeValid), 32'h0);
    give_verdict();
  end
endmodule : can_message_object_fifo_tb_top
`default_nettype wire
